/* verification/sbid_host_model.sv */
// host-side model that issues link requests and collects the answers
`timescale 1ns/1ps
`default_nettype none
module sbid_host_model (
    input wire logic i_lnk_clk,            // link clock
    input wire logic i_lnk_ready,          // design can take a request
    input wire logic i_lnk_rvalid,         // answer strobe
    input wire logic [7:0] i_lnk_rdata,    // answer byte
    output logic o_lnk_req,                // request strobe
    output sbid_pkg::sbid_req_s o_lnk_cmd  // request fields
);
    initial begin
        o_lnk_req = 1'b0;
        o_lnk_cmd = '0;
    end
    // one request at a time; a start then one next per acked byte
    task automatic xfer(input sbid_pkg::sbid_op_e op, input logic [7:0] idx,
            input logic [7:0] wd, input int gap, output logic [7:0] rd, output logic ok);
        int n;
        ok = 1'b0;
        rd = 8'h00;
        repeat (gap) @(negedge i_lnk_clk);
        @(negedge i_lnk_clk);
        o_lnk_req = 1'b1;
        o_lnk_cmd = '{op: op, index: idx, wdata: wd};
        for (n = 0; n < 50 && !ok; n++) begin
            @(posedge i_lnk_clk);
            ok = (i_lnk_ready === 1'b1);
        end
        if (!ok) return;
        @(negedge i_lnk_clk);
        o_lnk_req = 1'b0;
        // released fields must not keep looking like the last request
        o_lnk_cmd = ~o_lnk_cmd;
        ok = 1'b0;
        for (n = 0; n < 60 && !ok; n++) begin
            @(posedge i_lnk_clk);
            ok = (i_lnk_rvalid === 1'b1);
        end
        rd = i_lnk_rdata;
    endtask
endmodule
`default_nettype wire

/* verification/smbus_id_and_byte_count_regs_bench.sv */
// self-checking bench for the identification and read-length register bank
`timescale 1ns/1ps
`default_nettype none
module smbus_id_and_byte_count_regs_bench;
    localparam logic [3:0] REV = 4'h3;    // arbitrary value
    localparam logic [3:0] VEND = 4'h9;   // arbitrary value
    localparam logic [1:0] DTYPE = 2'h2;  // arbitrary value
    localparam logic [5:0] DCODE = 6'h15; // arbitrary value
    localparam logic [7:0] REV_VEND_VAL = {REV, VEND};
    localparam logic [7:0] TYPE_CODE_VAL = {DTYPE, DCODE};
    logic ref_clk = 1'b0;
    logic lnk_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic lnk_rst = 1'b1;
    logic lnk_req;
    sbid_pkg::sbid_req_s lnk_cmd;
    logic lnk_ready;
    logic lnk_rvalid;
    logic [7:0] lnk_rdata;
    logic [4:0] readback_length;
    int miscompares = 0;
    int num_checks = 0;
    initial forever #4 ref_clk = ~ref_clk;
    // link clock offset so its edges never line up with the core clock
    initial begin
        #1.7;
        forever #3 lnk_clk = ~lnk_clk;
    end
    sbid_regs #(.REVISION_CODE(REV), .VENDOR_CODE(VEND), .DEVICE_TYPE(DTYPE),
            .DEVICE_CODE(DCODE)) i_dut (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
        .i_lnk_clk(lnk_clk), .i_lnk_rst(lnk_rst), .i_lnk_req(lnk_req),
        .i_lnk_cmd(lnk_cmd), .o_lnk_ready(lnk_ready), .o_lnk_rvalid(lnk_rvalid),
        .o_lnk_rdata(lnk_rdata), .o_readback_length(readback_length));
    sbid_host_model i_host (.i_lnk_clk(lnk_clk), .i_lnk_ready(lnk_ready),
        .i_lnk_rvalid(lnk_rvalid), .i_lnk_rdata(lnk_rdata), .o_lnk_req(lnk_req),
        .o_lnk_cmd(lnk_cmd));
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic req(input sbid_pkg::sbid_op_e op, input logic [7:0] idx,
            input logic [7:0] wd, input int gap, output logic [7:0] rd);
        logic ok;
        i_host.xfer(op, idx, wd, gap, rd, ok);
        if (ok !== 1'b1) begin
            miscompares++;
            test_done();
        end
    endtask
    task automatic t_defaults();
        logic [7:0] rd;
        check({3'h0, readback_length}, 8'h08);
        req(sbid_pkg::SBID_OP_RD_START, 8'h05, 8'h00, 0, rd);
        check(rd, 8'h08);
        req(sbid_pkg::SBID_OP_RD_NEXT, 8'h00, 8'h00, 0, rd);
        check(rd, REV_VEND_VAL);
        req(sbid_pkg::SBID_OP_RD_NEXT, 8'h00, 8'h00, 4, rd);
        check(rd, TYPE_CODE_VAL);
        req(sbid_pkg::SBID_OP_RD_NEXT, 8'h00, 8'h00, 0, rd);
        check(rd, 8'h08);
    endtask
    task automatic t_ro_writes();
        logic [7:0] rd;
        req(sbid_pkg::SBID_OP_WRITE, 8'h05, ~REV_VEND_VAL, 0, rd);
        req(sbid_pkg::SBID_OP_WRITE, 8'h06, ~TYPE_CODE_VAL, 0, rd);
        req(sbid_pkg::SBID_OP_IDLE, 8'h07, 8'h01, 0, rd);
        req(sbid_pkg::SBID_OP_RD_START, 8'h05, 8'h00, 0, rd);
        check(rd, 8'h08);
        req(sbid_pkg::SBID_OP_RD_NEXT, 8'h00, 8'h00, 0, rd);
        check(rd, REV_VEND_VAL);
        req(sbid_pkg::SBID_OP_RD_NEXT, 8'h00, 8'h00, 0, rd);
        check(rd, TYPE_CODE_VAL);
    endtask
    task automatic t_len_full();
        logic [7:0] rd;
        req(sbid_pkg::SBID_OP_WRITE, 8'h07, 8'hff, 0, rd);
        @(negedge ref_clk);
        check({3'h0, readback_length}, 8'h1f);
        req(sbid_pkg::SBID_OP_RD_START, 8'h07, 8'h00, 0, rd);
        check(rd, 8'h1f);
        req(sbid_pkg::SBID_OP_RD_NEXT, 8'h00, 8'h00, 0, rd);
        check(rd, 8'h1f);
        req(sbid_pkg::SBID_OP_RD_NEXT, 8'h00, 8'h00, 0, rd);
        check(rd, 8'hff);
    endtask
    task automatic t_len_limit();
        logic [7:0] rd;
        req(sbid_pkg::SBID_OP_WRITE, 8'h07, 8'h02, 0, rd);
        req(sbid_pkg::SBID_OP_RD_START, 8'h06, 8'h00, 0, rd);
        check(rd, 8'h02);
        req(sbid_pkg::SBID_OP_RD_NEXT, 8'h00, 8'h00, 0, rd);
        check(rd, TYPE_CODE_VAL);
        req(sbid_pkg::SBID_OP_RD_NEXT, 8'h00, 8'h00, 0, rd);
        check(rd, 8'h02);
        req(sbid_pkg::SBID_OP_RD_NEXT, 8'h00, 8'h00, 0, rd);
        check(rd, 8'hff);
        req(sbid_pkg::SBID_OP_WRITE, 8'h07, 8'h00, 0, rd);
        req(sbid_pkg::SBID_OP_RD_START, 8'h05, 8'h00, 0, rd);
        check(rd, 8'h00);
        req(sbid_pkg::SBID_OP_RD_NEXT, 8'h00, 8'h00, 0, rd);
        check(rd, 8'hff);
    endtask
    task automatic do_reset(input int cycles);
        @(negedge ref_clk);
        sys_rst = 1'b1;
        @(negedge lnk_clk);
        lnk_rst = 1'b1;
        repeat (cycles) @(negedge ref_clk);
        sys_rst = 1'b0;
        @(negedge lnk_clk);
        lnk_rst = 1'b0;
    endtask
    initial begin
        do_reset(20);
        t_defaults();
        t_ro_writes();
        t_len_full();
        t_len_limit();
        // a second reset must bring the written length back to eight
        do_reset(3);
        t_defaults();
        test_done();
    end
endmodule
`default_nettype wire

/* verilog/sbid_pkg.sv */
// shared constants and types for the identification and read-length register bank
package sbid_pkg;
    localparam logic [7:0] ADDR_REV_VENDOR = 8'h05;
    localparam logic [7:0] ADDR_DEV_TYPE = 8'h06;
    localparam logic [7:0] ADDR_READ_LEN = 8'h07;
    localparam int REV_MSB = 7;
    localparam int REV_LSB = 4;
    localparam int VENDOR_MSB = 3;
    localparam int VENDOR_LSB = 0;
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 6;
    localparam int DEVCODE_MSB = 5;
    localparam int DEVCODE_LSB = 0;
    localparam int LEN_MSB = 4;
    localparam int LEN_W = 5;
    localparam logic [4:0] READ_LEN_RST = 5'h08;
    localparam logic [7:0] UNMAPPED_DATA = 8'hff;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        SBID_OP_IDLE = 2'b00,
        SBID_OP_WRITE = 2'b01,
        SBID_OP_RD_START = 2'b10,
        SBID_OP_RD_NEXT = 2'b11
    } sbid_op_e;

    typedef struct packed {
        sbid_op_e op;
        logic [7:0] index;
        logic [7:0] wdata;
    } sbid_req_s;
endpackage

/* verilog/sbid_regs.sv */
// identification and read-length register bank with its link-side crossing
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - revision_vendor_code: revision code in bits 7..4, vendor code in 3..0, read-only
// - device_type_code: device type in bits 7..6, device code in 5..0, read-only
// - block_read_length: five-bit read-write length in bits 4..0, bits 7..5 reserved
// - written length sets bytes returned in a block read; resets to eight
// - block read sends the length first, then bytes from the start index
module sbid_regs #(
    parameter logic [3:0] REVISION_CODE = 4'h2,  // arbitrary value
    parameter logic [3:0] VENDOR_CODE = 4'h5,    // arbitrary value
    parameter logic [1:0] DEVICE_TYPE = 2'h3,    // arbitrary value
    parameter logic [5:0] DEVICE_CODE = 6'h2a    // arbitrary value
) (
    input wire logic i_ref_clk,                  // core clock, 125 MHz
    input wire logic i_sys_rst,                  // core reset, synchronous, high
    input wire logic i_lnk_clk,                  // clock of the bus engine side
    input wire logic i_lnk_rst,                  // link reset, synchronous, high
    input wire logic i_lnk_req,                  // request strobe, link clock
    input wire sbid_pkg::sbid_req_s i_lnk_cmd,   // request op, index, write data
    output logic o_lnk_ready,                    // request may be taken
    output logic o_lnk_rvalid,                   // request done, one link cycle
    output logic [7:0] o_lnk_rdata,              // byte returned with rvalid
    output logic [4:0] o_readback_length         // current read length, core clock
);
    // ---------------- link domain ----------------
    sbid_pkg::sbid_req_s lnk_hold_r;
    logic lnk_tgl_r;
    logic lnk_busy_r;
    logic lnk_ack_seen_r;
    logic lnk_rvalid_r;
    logic [7:0] lnk_rdata_r;
    logic lnk_ack_sync;
    logic lnk_take;
    logic lnk_ack_edge;
    logic core_ack_tgl_r;
    logic [7:0] core_rsp_r;

    assign lnk_take = i_lnk_req && !lnk_busy_r;
    assign lnk_ack_edge = lnk_ack_sync ^ lnk_ack_seen_r;

    sbid_sync2 #(.W(1)) u_ack_sync (
        .i_clk(i_lnk_clk),
        .i_rst(i_lnk_rst),
        .i_d(core_ack_tgl_r),
        .o_q(lnk_ack_sync)
    );

    // request word is held still while busy, so the core may sample it freely
    always_ff @(posedge i_lnk_clk) begin
        if (i_lnk_rst) begin
            lnk_hold_r <= '0;
            lnk_tgl_r <= 1'b0;
            lnk_busy_r <= 1'b0;
        end else if (lnk_take) begin
            lnk_hold_r <= i_lnk_cmd;
            lnk_tgl_r <= ~lnk_tgl_r;
            lnk_busy_r <= 1'b1;
        end else if (lnk_ack_edge) begin
            lnk_busy_r <= 1'b0;
        end
    end

    // response byte is stable in the core when its ack toggle is seen here
    always_ff @(posedge i_lnk_clk) begin
        if (i_lnk_rst) begin
            lnk_ack_seen_r <= 1'b0;
            lnk_rvalid_r <= 1'b0;
            lnk_rdata_r <= 8'h00;
        end else begin
            lnk_ack_seen_r <= lnk_ack_sync;
            lnk_rvalid_r <= lnk_ack_edge;
            if (lnk_ack_edge) begin
                lnk_rdata_r <= core_rsp_r;
            end
        end
    end

    assign o_lnk_ready = !lnk_busy_r;
    assign o_lnk_rvalid = lnk_rvalid_r;
    assign o_lnk_rdata = lnk_rdata_r;

    // ---------------- core domain ----------------
    logic core_req_sync;
    logic core_seen_r;
    logic [4:0] len_r;
    logic [7:0] ptr_r;
    logic [4:0] remain_r;
    logic core_new;
    logic is_write;
    logic is_start;
    logic is_next;
    logic len_hit;
    logic have_more;
    logic [7:0] ptr_data;

    function automatic logic [7:0] read_map(input logic [7:0] idx, input logic [4:0] len);
        logic [7:0] v;
        v = sbid_pkg::UNMAPPED_DATA;
        case (idx)
            sbid_pkg::ADDR_REV_VENDOR: v = {REVISION_CODE, VENDOR_CODE};
            sbid_pkg::ADDR_DEV_TYPE: v = {DEVICE_TYPE, DEVICE_CODE};
            sbid_pkg::ADDR_READ_LEN: v = {3'h0, len};
            default: v = sbid_pkg::UNMAPPED_DATA;
        endcase
        return v;
    endfunction

    sbid_sync2 #(.W(1)) u_req_sync (
        .i_clk(i_ref_clk),
        .i_rst(i_sys_rst),
        .i_d(lnk_tgl_r),
        .o_q(core_req_sync)
    );

    assign core_new = core_req_sync ^ core_seen_r;
    assign is_write = core_new && (lnk_hold_r.op == sbid_pkg::SBID_OP_WRITE);
    assign is_start = core_new && (lnk_hold_r.op == sbid_pkg::SBID_OP_RD_START);
    assign is_next = core_new && (lnk_hold_r.op == sbid_pkg::SBID_OP_RD_NEXT);
    assign len_hit = lnk_hold_r.index == sbid_pkg::ADDR_READ_LEN;
    assign have_more = remain_r != 5'h00;
    assign ptr_data = read_map(ptr_r, len_r);

    // only the length field is stored; id bytes and bits 7..5 drop the write
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            len_r <= sbid_pkg::READ_LEN_RST;
        end else if (is_write && len_hit) begin
            len_r <= lnk_hold_r.wdata[sbid_pkg::LEN_MSB:0];
        end
    end

    // a block read returns the length first, then at most that many bytes
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ptr_r <= 8'h00;
            remain_r <= 5'h00;
            core_rsp_r <= 8'h00;
        end else if (is_start) begin
            ptr_r <= lnk_hold_r.index;
            remain_r <= len_r;
            core_rsp_r <= {3'h0, len_r};
        end else if (is_next && have_more) begin
            ptr_r <= ptr_r + 8'h01;
            remain_r <= remain_r - 5'h01;
            core_rsp_r <= ptr_data;
        end else if (is_next) begin
            core_rsp_r <= sbid_pkg::UNMAPPED_DATA;
        end
    end

    // ack toggles on the edge that sets the answer; the far side's two flops
    // give the answer byte time to settle before it is sampled there
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            core_seen_r <= 1'b0;
            core_ack_tgl_r <= 1'b0;
        end else if (core_new) begin
            core_seen_r <= core_req_sync;
            core_ack_tgl_r <= ~core_ack_tgl_r;
        end
    end

    assign o_readback_length = len_r;

    // ---------------- checks ----------------
    sequence s_next_at(logic [7:0] a);
        is_next && have_more && ptr_r == a;
    endsequence

    sequence s_start;
        is_start;
    endsequence

    chk_rev_vendor_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        s_next_at(sbid_pkg::ADDR_REV_VENDOR) |=> core_rsp_r == {REVISION_CODE, VENDOR_CODE})
        else $error("revision and vendor byte read wrong");

    chk_type_code_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        s_next_at(sbid_pkg::ADDR_DEV_TYPE) |=> core_rsp_r == {DEVICE_TYPE, DEVICE_CODE})
        else $error("device type byte read wrong");

    chk_length_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        is_write && len_hit |=> len_r == $past(lnk_hold_r.wdata[4:0]))
        else $error("length write not stored");

    chk_length_reset: assert property (@(posedge i_ref_clk)
        i_sys_rst |=> len_r == 5'h08)
        else $error("length not eight after reset");

    chk_start_sends_len: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        s_start |=> core_rsp_r == {3'h0, $past(len_r)} && remain_r == $past(len_r)
            && ptr_r == $past(lnk_hold_r.index))
        else $error("block read start wrong");

    chk_next_advances: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        is_next && have_more |=> ptr_r == $past(ptr_r) + 8'h01
            && remain_r == $past(remain_r) - 5'h01)
        else $error("block read did not advance");

    chk_len_limits_read: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        is_next && !have_more |=> core_rsp_r == 8'hff && $stable(ptr_r))
        else $error("read ran past the length");

    chk_ro_write_ignored: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        is_write && !len_hit |=> $stable(len_r))
        else $error("write to read-only byte changed state");

    chk_link_answers: assert property (@(posedge i_lnk_clk) disable iff (i_lnk_rst)
        lnk_take |-> ##[3:40] lnk_rvalid_r)
        else $error("link request not answered");

    chk_len_read_back: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        s_next_at(sbid_pkg::ADDR_READ_LEN) |=> core_rsp_r == {3'h0, $past(len_r)})
        else $error("length byte read wrong");

    // a taken request must drop ready on the next link cycle
    chk_ready_drops: assert property (@(posedge i_lnk_clk) disable iff (i_lnk_rst)
        lnk_take |=> !o_lnk_ready)
        else $error("ready stayed high after a take");

    chk_rdata_held: assert property (@(posedge i_lnk_clk) disable iff (i_lnk_rst)
        !lnk_ack_edge |=> $stable(o_lnk_rdata))
        else $error("answer byte changed without an answer");
endmodule
`default_nettype wire

/* verilog/sbid_sync2.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sbid_sync2 #(
    parameter int W = 1
) (
    input wire logic i_clk,          // destination clock
    input wire logic i_rst,          // destination reset, synchronous, high
    input wire logic [W-1:0] i_d,    // level from the other domain
    output logic [W-1:0] o_q         // synchronised level
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // the first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= i_d;
            q_r <= meta_r;
        end
    end

    assign o_q = q_r;
endmodule
`default_nettype wire
